// [src/mml_top.sv]
// Min/max parameter log with windowed readout behind a request/reply port.
// Assumes framing and CRC are handled outside; requests arrive decoded.
`timescale 1ns/1ps
`include "mml_defs.svh"

module mml_top import mml_pkg::*; #(
	parameter int RSP_LIMIT_CYC = `MML_RSP_CMD_NS / `MML_CLK_NS
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	// Measurement samples
	input  wire logic        samp_valid_i,
	input  wire logic [5:0]  samp_idx_i,
	input  wire logic [15:0] samp_val_i,
	output logic             samp_ready_o,
	// Decoded requests
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_func_i,
	input  wire logic [15:0] req_addr_i,
	input  wire logic [15:0] req_qty_i,
	input  wire logic [15:0] req_wdata_i,
	output logic             req_ready_o,
	// Reply beats
	output logic             rsp_valid_o,
	output logic             rsp_first_o,
	output logic             rsp_last_o,
	output logic      [7:0]  rsp_func_o,
	output logic      [7:0]  rsp_exc_o,
	output logic      [15:0] rsp_data_o
);

	function automatic logic val_gt(input logic [15:0] a, input logic [15:0] b,
		input logic sgn);
		val_gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
	endfunction : val_gt

	mml_state_type state_reg;
	mml_state_type state_next;
	mml_src_type   src_reg;
	mml_src_type   src_next;

	logic        req_take;
	logic        is_rd;
	logic        is_wr1;
	logic        is_wrn;
	logic [7:0]  sel_first;
	logic [7:0]  sel_cnt;
	logic        val_ok;
	logic        rd_sel_hit;
	logic        rd_buf_hit;
	logic [7:0]  exc_next;
	logic        wr_ok;
	logic [6:0]  beats_next;

	logic [7:0]  func_reg;
	logic [7:0]  exc_reg;
	logic [5:0]  ptr_reg;
	logic [6:0]  beats_reg;
	logic [15:0] echo_a_reg;
	logic [15:0] echo_b_reg;
	logic [15:0] sel_reg;
	logic [5:0]  first_reg;
	logic [6:0]  cnt_reg;
	logic [6:0]  k_reg;
	logic        cp_v_reg;
	logic [5:0]  cp_k_reg;
	logic        cp_vld_reg;
	logic [31:0] lat_cnt_reg;

	logic        s_take;
	logic        s1_v_reg;
	logic [5:0]  s1_idx_reg;
	logic [15:0] s1_val_reg;
	logic [63:0] vld_reg;
	logic        s1_vld;
	logic        s1_sgn;
	logic        s1_is_max;
	logic        s1_is_min;
	logic        log_we;
	logic [5:0]  log_raddr;
	logic [15:0] log_rdata;
	logic [5:0]  copy_idx;
	logic [15:0] buf_wdata;
	logic [15:0] buf_rdata;
	logic [15:0] data_next;
	logic [7:0]  hdr_func;

	// Request decode
	assign req_take   = req_valid_i & req_ready_o;
	assign is_rd      = (req_func_i == `MML_FC_RD);
	assign is_wr1     = (req_func_i == `MML_FC_WR1);
	assign is_wrn     = (req_func_i == `MML_FC_WRN);
	assign sel_first  = req_wdata_i[`MML_SEL_FIRST_LSB +: 8];
	assign sel_cnt    = req_wdata_i[`MML_SEL_CNT_LSB +: 8];
	assign val_ok     = (sel_cnt != 8'h00) && (sel_cnt <= `MML_CNT_MAX) &&
		(({1'b0, sel_first} + {1'b0, sel_cnt}) <= `MML_RANGE_END);
	assign rd_sel_hit = (req_addr_i == `MML_SEL_ADDR) && (req_qty_i == 16'h0001);
	assign rd_buf_hit = (req_addr_i >= `MML_BUF_ADDR) &&
		(({1'b0, req_addr_i} + {1'b0, req_qty_i}) <= `MML_BUF_END);

	// Code checked before any data field, so dataless codes need no operands
	assign exc_next =
		!(is_rd || is_wr1 || is_wrn) ? `MML_EXC_FUNC :
		is_rd ? ((req_qty_i == 16'h0000) ? `MML_EXC_VAL :
			(rd_sel_hit || rd_buf_hit) ? `MML_EXC_NONE : `MML_EXC_ADDR) :
		(req_addr_i != `MML_SEL_ADDR) ? `MML_EXC_ADDR :
		(is_wrn && (req_qty_i != 16'h0001)) ? `MML_EXC_VAL :
		val_ok ? `MML_EXC_NONE : `MML_EXC_VAL;
	assign wr_ok      = (is_wr1 || is_wrn) && (exc_next == `MML_EXC_NONE);
	assign src_next   = !is_rd ? SRC_ECHO : rd_sel_hit ? SRC_SEL : SRC_BUF;
	assign beats_next = !is_rd ? 7'h02 : rd_sel_hit ? 7'h01 : req_qty_i[6:0];

	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_take)
					state_next = wr_ok ? ST_COPY : ST_HDR;
			end
			ST_COPY: begin
				if (k_reg == cnt_reg - 7'h01)
					state_next = ST_HDR;
			end
			ST_HDR: begin
				state_next = (exc_reg != `MML_EXC_NONE) ? ST_IDLE : ST_DATA;
			end
			ST_DATA: begin
				if (beats_reg == 7'h01)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_reg   <= ST_IDLE;
			req_ready_o <= 1'b0;
		end else begin
			state_reg   <= state_next;
			req_ready_o <= (state_next == ST_IDLE);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			func_reg   <= 8'h00;
			exc_reg    <= `MML_EXC_NONE;
			src_reg    <= SRC_BUF;
			echo_a_reg <= 16'h0000;
			echo_b_reg <= 16'h0000;
		end else if (req_take) begin
			func_reg   <= req_func_i;
			exc_reg    <= exc_next;
			src_reg    <= src_next;
			echo_a_reg <= req_addr_i;
			echo_b_reg <= is_wr1 ? req_wdata_i : req_qty_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sel_reg   <= `MML_SEL_RST;
			first_reg <= 6'h00;
			cnt_reg   <= 7'h00;
		end else if (req_take && wr_ok) begin
			sel_reg   <= req_wdata_i;
			first_reg <= sel_first[5:0];
			cnt_reg   <= sel_cnt[6:0];
		end
	end

	// Copy selected log words into the buffer
	assign copy_idx  = 6'(first_reg + k_reg[5:0]);
	assign log_raddr = (state_reg == ST_COPY) ? copy_idx : samp_idx_i;
	assign buf_wdata = cp_vld_reg ? log_rdata : 16'h0000;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			k_reg      <= 7'h00;
			cp_v_reg   <= 1'b0;
			cp_k_reg   <= 6'h00;
			cp_vld_reg <= 1'b0;
		end else begin
			k_reg      <= (state_reg == ST_COPY) ? k_reg + 7'h01 : 7'h00;
			cp_v_reg   <= (state_reg == ST_COPY);
			cp_k_reg   <= k_reg[5:0];
			cp_vld_reg <= vld_reg[copy_idx];
		end
	end

	// Buffer read pointer and beat count
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ptr_reg   <= 6'h00;
			beats_reg <= 7'h00;
		end else if (req_take) begin
			ptr_reg   <= 6'(req_addr_i - `MML_BUF_ADDR);
			beats_reg <= beats_next;
		end else if (state_reg == ST_HDR) begin
			ptr_reg   <= ptr_reg + 6'h01;
		end else if (state_reg == ST_DATA) begin
			ptr_reg   <= ptr_reg + 6'h01;
			beats_reg <= beats_reg - 7'h01;
		end
	end

	// Sample pipeline; a sample seen during a copy start may land one late
	assign s_take    = samp_valid_i & samp_ready_o;
	assign s1_vld    = vld_reg[s1_idx_reg];
	assign s1_sgn    = 1'(`MML_SIGNED_MAP >> s1_idx_reg);
	assign s1_is_max = (s1_idx_reg <= `MML_MAX_LAST);
	assign s1_is_min = (s1_idx_reg >= `MML_MIN_FIRST) &&
		(s1_idx_reg <= `MML_MIN_LAST);
	assign log_we    = s1_v_reg && (
		(s1_is_max && (!s1_vld || val_gt(s1_val_reg, log_rdata, s1_sgn))) ||
		(s1_is_min && (!s1_vld || val_gt(log_rdata, s1_val_reg, s1_sgn))));

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			samp_ready_o <= 1'b0;
			s1_v_reg     <= 1'b0;
			s1_idx_reg   <= 6'h00;
			s1_val_reg   <= 16'h0000;
			vld_reg      <= 64'h0000_0000_0000_0000;
		end else begin
			// One sample per two cycles avoids read-after-write forwarding
			samp_ready_o <= !s_take && (state_next != ST_COPY);
			s1_v_reg     <= s_take;
			s1_idx_reg   <= samp_idx_i;
			s1_val_reg   <= samp_val_i;
			if (log_we)
				vld_reg[s1_idx_reg] <= 1'b1;
		end
	end

	mml_mem #(.WIDTH(16), .DEPTH(64), .AW(6)) u_log_mem (
		.core_clk_i (core_clk_i),
		.we_i       (log_we),
		.waddr_i    (s1_idx_reg),
		.wdata_i    (s1_val_reg),
		.raddr_i    (log_raddr),
		.rdata_o    (log_rdata)
	);

	mml_mem #(.WIDTH(16), .DEPTH(64), .AW(6)) u_buf_mem (
		.core_clk_i (core_clk_i),
		.we_i       (cp_v_reg),
		.waddr_i    (cp_k_reg),
		.wdata_i    (buf_wdata),
		.raddr_i    (ptr_reg),
		.rdata_o    (buf_rdata)
	);

	// Reply beats
	assign hdr_func  = (exc_reg != `MML_EXC_NONE) ?
		(func_reg | 8'h80) : func_reg;
	assign data_next = (src_reg == SRC_BUF) ? buf_rdata :
		(src_reg == SRC_SEL) ? sel_reg :
		(beats_reg == 7'h02) ? echo_a_reg : echo_b_reg;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_first_o <= 1'b0;
			rsp_last_o  <= 1'b0;
			rsp_func_o  <= 8'h00;
			rsp_exc_o   <= `MML_EXC_NONE;
			rsp_data_o  <= 16'h0000;
		end else begin
			// Beats only follow an accepted request
			rsp_valid_o <= (state_reg == ST_HDR) || (state_reg == ST_DATA);
			rsp_first_o <= (state_reg == ST_HDR);
			rsp_last_o  <= ((state_reg == ST_HDR) &&
				(exc_reg != `MML_EXC_NONE)) ||
				((state_reg == ST_DATA) && (beats_reg == 7'h01));
			rsp_func_o  <= hdr_func;
			rsp_exc_o   <= exc_reg;
			rsp_data_o  <= (state_reg == ST_DATA) ? data_next : 16'h0000;
		end
	end

	// Cycles from acceptance to the header beat
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || req_take)
			lat_cnt_reg <= 32'h0000_0000;
		else if ((state_reg == ST_COPY) || (state_reg == ST_HDR))
			lat_cnt_reg <= lat_cnt_reg + 32'h0000_0001;
	end

	AST_LAT_LIMIT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		lat_cnt_reg < RSP_LIMIT_CYC)
		else $error("reply start exceeds latency limit");
	AST_MAX_TRACK: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(s1_v_reg && s1_is_max && (!s1_vld ||
		val_gt(s1_val_reg, log_rdata, s1_sgn))) |=>
		vld_reg[$past(s1_idx_reg)] && !s1_v_reg)
		else $error("new maximum not stored");
	AST_MIN_HOLD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(s1_v_reg && s1_is_min && s1_vld &&
		!val_gt(log_rdata, s1_val_reg, s1_sgn)) |-> !log_we)
		else $error("minimum overwritten by larger sample");
	AST_SEL_WRITE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_take && wr_ok) |=> (sel_reg == $past(req_wdata_i)) &&
		(state_reg == ST_COPY))
		else $error("select register not loaded");
	AST_COUNT_LIMIT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_take && is_wr1 && (req_addr_i == `MML_SEL_ADDR) &&
		(sel_cnt > `MML_CNT_MAX)) |-> ##2 rsp_first_o &&
		(rsp_exc_o == `MML_EXC_VAL))
		else $error("oversize count not refused");
	AST_COPY_LEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_take && wr_ok) |-> ##2 cp_v_reg ##[1:64] rsp_first_o)
		else $error("copy did not end in a reply");
	AST_ECHO_FUNC: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(rsp_first_o && (rsp_exc_o == `MML_EXC_NONE)) |->
		(rsp_func_o == func_reg) && !rsp_last_o)
		else $error("normal reply code altered");
	AST_EXC_FORM: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(rsp_first_o && (rsp_exc_o != `MML_EXC_NONE)) |->
		rsp_func_o[`MML_EXC_BIT] && rsp_last_o ##1 !rsp_valid_o)
		else $error("exception reply malformed");
	AST_BAD_FUNC: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_take && !(is_rd || is_wr1 || is_wrn)) |->
		##2 rsp_first_o && (rsp_exc_o == `MML_EXC_FUNC))
		else $error("unsupported code not refused");
	AST_NO_UNSOLICITED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(state_reg == ST_IDLE) |=> !rsp_valid_o)
		else $error("reply without request");
	AST_RANGE_KEEP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_take && is_wr1 && (req_addr_i == `MML_SEL_ADDR) && !val_ok) |=>
		(!cp_v_reg)[*2] ##0 (sel_reg == $past(sel_reg, 2)))
		else $error("bad range touched buffer");

endmodule : mml_top

// [src/mml_defs.svh]
// Constants for the min/max log readout block: offsets, fields, codes, timing.
// Assumes inclusion by bare name from the block's design and bench files.
//
// Overview of operation
// - Keep running max for indices 0-32, running min for 34-50.
// - Select register: low byte first index, high byte parameter count.
// - One readout returns 1 to 64 parameters; larger counts are not allowed.
// - Writing the select register copies chosen log values into the buffer.
// - Buffer word k holds parameter first+k, starting at the buffer base.
// - Values are 16-bit, signed or unsigned per parameter, fixed scaling.
// - Indices up to 32 are maxima; 34 to 50 are minima.
// - Reply begins within 2.5 ms for command registers, 8 ms for configuration.
// - Server only: a reply is sent only for a received request.
// - Function code is one byte; 1-127 requests, 128-255 exceptions, 0 invalid.
// - A request with no data field is acted on by function code alone.
// - Normal reply repeats the request's function code unchanged.
// - Exception reply sets the function code's top bit and adds a code.
// - Exception 01 bad function, 02 bad address, 03 bad value or count.
// - Only function codes 3, 6 and 16 are supported.
`ifndef MML_DEFS_SVH
`define MML_DEFS_SVH

`define MML_SEL_ADDR     16'hA262
`define MML_BUF_ADDR     16'hA264
`define MML_BUF_END      17'h0A2A4
`define MML_SEL_RST      16'h0000
`define MML_SEL_FIRST_LSB 0
`define MML_SEL_CNT_LSB  8
`define MML_CNT_MAX      8'h40
`define MML_RANGE_END    9'h033
`define MML_MAX_LAST     6'h20
`define MML_MIN_FIRST    6'h22
`define MML_MIN_LAST     6'h32
`define MML_SIGNED_MAP   64'h0007_FFED_FDFC_3000

`define MML_FC_RD        8'h03
`define MML_FC_WR1       8'h06
`define MML_FC_WRN       8'h10
`define MML_EXC_BIT      7
`define MML_EXC_NONE     8'h00
`define MML_EXC_FUNC     8'h01
`define MML_EXC_ADDR     8'h02
`define MML_EXC_VAL      8'h03

`define MML_CLK_NS       8
`define MML_RSP_CMD_NS   2500000
`define MML_RSP_CFG_NS   8000000

`endif

// [src/mml_pkg.sv]
// Types for the min/max log readout block.
// Assumes mml_defs.svh supplies the numeric constants.
package mml_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_COPY = 4'b0010,
		ST_HDR  = 4'b0100,
		ST_DATA = 4'b1000
	} mml_state_type;

	typedef enum logic [1:0] {
		SRC_BUF  = 2'h0,
		SRC_SEL  = 2'h1,
		SRC_ECHO = 2'h2
	} mml_src_type;

endpackage : mml_pkg

// [src/mml_mem.sv]
// Small one-write one-read memory with registered read data.
// Assumes a single clock; read returns the old word on a same-address write.
`timescale 1ns/1ps

module mml_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// Clock
	input  wire logic             core_clk_i,
	// Write port
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// Read port
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge core_clk_i) begin
		if (we_i)
			mem_reg[waddr_i] <= wdata_i;
		rdata_o <= mem_reg[raddr_i];
	end

endmodule : mml_mem

// [dv/mml_master_model.sv]
// Remote master model driving decoded requests into the readout block.
// Assumes one request in flight; it holds each request until ready is seen.
`timescale 1ns/1ps

module mml_master_model (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	// Decoded requests
	output logic             req_valid_o,
	output logic      [7:0]  req_func_o,
	output logic      [15:0] req_addr_o,
	output logic      [15:0] req_qty_o,
	output logic      [15:0] req_wdata_o,
	input  wire logic        req_ready_i
);
	int cyc_reg;
	int take_reg;

	initial begin
		req_valid_o = 1'b0;
		req_func_o  = 8'h00;
		req_addr_o  = 16'h0000;
		req_qty_o   = 16'h0000;
		req_wdata_o = 16'h0000;
	end

	always @(posedge core_clk_i) begin
		cyc_reg <= sys_rst_i ? 0 : cyc_reg + 1;
	end

	// Gap of zero still waits one edge, so valid is never set twice in a step
	task automatic send(input logic [7:0] fc, input logic [15:0] ad,
		input logic [15:0] qt, input logic [15:0] wd, input int gap);
		repeat (gap + 1) @(posedge core_clk_i);
		req_valid_o <= 1'b1;
		req_func_o  <= fc;
		req_addr_o  <= ad;
		req_qty_o   <= qt;
		req_wdata_o <= wd;
		@(posedge core_clk_i);
		while (req_ready_i !== 1'b1) @(posedge core_clk_i);
		take_reg    <= cyc_reg;
		req_valid_o <= 1'b0;
		// Released lines show the inverse so stale values never look valid
		req_func_o  <= ~fc;
		req_addr_o  <= ~ad;
		req_qty_o   <= ~qt;
		req_wdata_o <= ~wd;
	endtask : send
endmodule : mml_master_model

// [dv/minmax_log_readout_tb_top.sv]
// Self-checking bench for the min/max log readout block.
// Assumes mml_master_model drives the request port of mml_top.
`timescale 1ns/1ps
`include "mml_defs.svh"

module minmax_log_readout_tb_top;
	localparam int LIMIT = 100;
	logic        core_clk_i = 1'b0;
	logic        sys_rst_i;
	logic        samp_valid_i;
	logic [5:0]  samp_idx_i;
	logic [15:0] samp_val_i;
	logic        samp_ready_o;
	logic        req_valid_i;
	logic [7:0]  req_func_i;
	logic [15:0] req_addr_i;
	logic [15:0] req_qty_i;
	logic [15:0] req_wdata_i;
	logic        req_ready_o;
	logic        rsp_valid_o;
	logic        rsp_first_o;
	logic        rsp_last_o;
	logic [7:0]  rsp_func_o;
	logic [7:0]  rsp_exc_o;
	logic [15:0] rsp_data_o;
	int          failures;
	int          total_checks;
	int          seed = 72067;
	logic [33:0] exp_q[$];
	logic [33:0] mon_exp;
	logic [33:0] mon_act;
	logic [15:0] log_val[64] = '{default: 16'h0000};
	bit          log_seen[64];
	logic [15:0] buf_val[64];
	logic [15:0] sel_val = `MML_SEL_RST;
	logic [15:0] bad_sel[5] = '{16'h0000, 16'h0005, 16'h4100, 16'h0232,
		16'h4000};
	logic [7:0]  bad_fc[6] = '{8'h00, 8'h01, 8'h04, 8'h7F, 8'h83, 8'hFF};

	mml_top #(.RSP_LIMIT_CYC(LIMIT)) mml_top_i (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.samp_valid_i(samp_valid_i), .samp_idx_i(samp_idx_i),
		.samp_val_i(samp_val_i), .samp_ready_o(samp_ready_o),
		.req_valid_i(req_valid_i), .req_func_i(req_func_i),
		.req_addr_i(req_addr_i), .req_qty_i(req_qty_i),
		.req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_first_o(rsp_first_o),
		.rsp_last_o(rsp_last_o), .rsp_func_o(rsp_func_o),
		.rsp_exc_o(rsp_exc_o), .rsp_data_o(rsp_data_o));

	mml_master_model mml_master_model_i (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.req_valid_o(req_valid_i), .req_func_o(req_func_i),
		.req_addr_o(req_addr_i), .req_qty_o(req_qty_i),
		.req_wdata_o(req_wdata_i), .req_ready_i(req_ready_o));

	always #4 core_clk_i = ~core_clk_i;

	task automatic fail(string m);
		failures++;
		$display("Error at %0t: %s", $time, m);
	endtask : fail

	function automatic bit is_sgn(int i);
		return i == 12 || i == 13 || (i >= 18 && i <= 50 && i != 25 &&
			i != 33 && i != 36);
	endfunction : is_sgn

	task automatic put_samp(int i, logic [15:0] v);
		bit upd;
		@(posedge core_clk_i);
		samp_valid_i <= 1'b1;
		samp_idx_i   <= i[5:0];
		samp_val_i   <= v;
		@(posedge core_clk_i);
		while (samp_ready_o !== 1'b1) @(posedge core_clk_i);
		samp_valid_i <= 1'b0;
		samp_val_i   <= ~v;
		if (is_sgn(i))
			upd = i <= 32 ? $signed(v) > $signed(log_val[i]) :
				$signed(v) < $signed(log_val[i]);
		else
			upd = i <= 32 ? v > log_val[i] : v < log_val[i];
		if ((i <= 32 || (i >= 34 && i <= 50)) && (!log_seen[i] || upd)) begin
			log_val[i]  = v;
			log_seen[i] = 1'b1;
		end
	endtask : put_samp

	task automatic beat(bit f, bit l, logic [7:0] fc, logic [7:0] ex,
		logic [15:0] d);
		exp_q.push_back({f, l, fc, ex, d});
	endtask : beat

	task automatic err(logic [7:0] fc, logic [15:0] ad, logic [15:0] qt,
		logic [7:0] ex);
		beat(1, 1, fc | 8'h80, ex, 16'h0000);
		mml_master_model_i.send(fc, ad, qt, 16'h0101, $random(seed) & 3);
	endtask : err

	task automatic wr_sel(logic [7:0] fc, logic [15:0] v);
		int first;
		int cnt;
		first = v[7:0];
		cnt   = v[15:8];
		if (cnt >= 1 && cnt <= 64 && first + cnt <= 51) begin
			beat(1, 0, fc, 8'h00, 16'h0000);
			beat(0, 0, 8'h00, 8'h00, `MML_SEL_ADDR);
			beat(0, 1, 8'h00, 8'h00, fc == `MML_FC_WR1 ? v : 16'h0001);
			sel_val = v;
			for (int k = 0; k < cnt; k++)
				buf_val[k] = log_val[first + k];
		end else begin
			beat(1, 1, fc | 8'h80, `MML_EXC_VAL, 16'h0000);
		end
		mml_master_model_i.send(fc, `MML_SEL_ADDR, 16'h0001, v,
			$random(seed) & 3);
	endtask : wr_sel

	task automatic rd(logic [15:0] ad, logic [15:0] qt);
		if (qt == 16'h0000) begin
			beat(1, 1, 8'h83, `MML_EXC_VAL, 16'h0000);
		end else if (ad == `MML_SEL_ADDR && qt == 16'h0001) begin
			beat(1, 0, `MML_FC_RD, 8'h00, 16'h0000);
			beat(0, 1, 8'h00, 8'h00, sel_val);
		end else if (ad >= `MML_BUF_ADDR && ad + qt <= `MML_BUF_END) begin
			beat(1, 0, `MML_FC_RD, 8'h00, 16'h0000);
			for (int k = 0; k < qt; k++)
				beat(0, k == qt - 1, 8'h00, 8'h00,
					buf_val[ad - `MML_BUF_ADDR + k]);
		end else begin
			beat(1, 1, 8'h83, `MML_EXC_ADDR, 16'h0000);
		end
		mml_master_model_i.send(`MML_FC_RD, ad, qt, 16'h0000,
			$random(seed) & 3);
	endtask : rd

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// Oldest note is taken off the queue for every reply beat
	always @(posedge core_clk_i) begin
		if (rsp_valid_o === 1'b1) begin
			total_checks++;
			mon_act = {rsp_first_o, rsp_last_o, rsp_func_o, rsp_exc_o,
				rsp_data_o};
			if (exp_q.size() == 0) begin
				fail("reply beat with no request pending");
			end else begin
				mon_exp = exp_q.pop_front();
				if (mon_exp[33] !== 1'b1)
					mon_act[31:16] = mon_exp[31:16];
				if (mon_act !== mon_exp)
					fail($sformatf("reply beat %h, expected %h", mon_act,
						mon_exp));
				if (mon_exp[33] && mml_master_model_i.cyc_reg -
					mml_master_model_i.take_reg > LIMIT)
					fail("reply header late");
			end
		end
	end

	initial begin
		repeat (60000) @(posedge core_clk_i);
		fail("watchdog expired");
		summarize();
	end

	initial begin
		sys_rst_i    = 1'b1;
		samp_valid_i = 1'b0;
		samp_idx_i   = 6'h00;
		samp_val_i   = 16'h0000;
		repeat (10) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rd(`MML_SEL_ADDR, 16'h0001);
		$display("Test done: select reset value");
		repeat (150) put_samp($random(seed) & 63, 16'($random(seed)));
		wr_sel(`MML_FC_WR1, 16'h3300);
		rd(`MML_BUF_ADDR, 16'h0033);
		wr_sel(`MML_FC_WR1, 16'h032F);
		rd(`MML_BUF_ADDR + 16'h0001, 16'h0002);
		wr_sel(`MML_FC_WRN, 16'h0132);
		rd(`MML_BUF_ADDR, 16'h0003);
		$display("Test done: copy and readout");
		foreach (bad_sel[k]) wr_sel(`MML_FC_WR1, bad_sel[k]);
		rd(`MML_SEL_ADDR, 16'h0001);
		rd(`MML_BUF_ADDR, 16'h0003);
		$display("Test done: refused select");
		rd(16'hA263, 16'h0001);
		rd(`MML_BUF_ADDR, 16'h0000);
		rd(`MML_BUF_ADDR, 16'h0041);
		rd(`MML_SEL_ADDR, 16'h0002);
		err(`MML_FC_WRN, `MML_SEL_ADDR, 16'h0002, `MML_EXC_VAL);
		err(`MML_FC_WR1, `MML_BUF_ADDR, 16'h0001, `MML_EXC_ADDR);
		foreach (bad_fc[k])
			err(bad_fc[k], `MML_SEL_ADDR, 16'h0001, `MML_EXC_FUNC);
		$display("Test done: exceptions");
		repeat (80) put_samp($random(seed) & 63, 16'($random(seed)));
		wr_sel(`MML_FC_WR1, 16'h3300);
		rd(`MML_BUF_ADDR, 16'h0033);
		$display("Test done: second copy");
		for (int k = 0; k < 200 && exp_q.size() > 0; k++)
			@(posedge core_clk_i);
		if (exp_q.size() != 0)
			fail("reply beats missing");
		summarize();
	end
endmodule : minmax_log_readout_tb_top
